// ===== src/esc_ctrl.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module esc_ctrl #(
  parameter int TICK_CYC = esc_pkg::TICK_CYC,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic on_ground_pin,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic ins_valid,
  input wire logic [11:0] ins_alt,
  input wire logic [1:0] ins_ss,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [2:0] tx_type,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_ant_bottom,
  output logic [2:0] ca_code,
  output logic cap_es
);

  // Millisecond time base
  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (rst || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // On-ground pin: three stages, change taken when stages two and three agree
  logic gnd_s1_r, gnd_s2_r, gnd_s3_r, gnd_r;
  logic gnd_nxt;
  assign gnd_nxt = (gnd_s2_r == gnd_s3_r) ? gnd_s3_r : gnd_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gnd_s1_r <= 1'b0;
      gnd_s2_r <= 1'b0;
      gnd_s3_r <= 1'b0;
      gnd_r <= 1'b0;
    end else begin
      gnd_s1_r <= on_ground_pin;
      gnd_s2_r <= gnd_s1_r;
      gnd_s3_r <= gnd_s2_r;
      gnd_r <= gnd_nxt;
    end
  end

  // Register bus decode
  logic [1:0] ctrl_r;
  logic sense_en, dual_ant;
  logic wr_ctrl, wr_event;
  localparam int NDREG_W = esc_pkg::NDREG;
  logic [NDREG_W-1:0] wr_dreg;
  assign sense_en = ctrl_r[esc_pkg::CTRL_SENSE_BIT];
  assign dual_ant = ctrl_r[esc_pkg::CTRL_DUAL_BIT];
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_CTRL));
  assign wr_event = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_EVENT));
  assign wr_dreg[esc_pkg::DR_APOS] = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_APOS));
  assign wr_dreg[esc_pkg::DR_SPOS] = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_SPOS));
  assign wr_dreg[esc_pkg::DR_IDENT] = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_IDENT));
  assign wr_dreg[esc_pkg::DR_AVEL] = reg_wr && (reg_addr == ADDR_W'(esc_pkg::ADR_AVEL));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= esc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  // Takeoff edge of the filtered on-ground level
  logic gnd_d_r;
  logic takeoff;
  assign takeoff = sense_en && gnd_d_r && !gnd_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gnd_d_r <= 1'b0;
    end else begin
      gnd_d_r <= gnd_r;
    end
  end

  // Ground format commands with timeout
  esc_pkg::esc_force_t force_r, force_nxt;
  logic [15:0] force_ms_r, force_ms_nxt;
  logic cmd_surf, cmd_air, cmd_lock, cmd_alt, cmd_top;
  assign cmd_surf = cmd_valid && (cmd_code == esc_pkg::CMD_SURF);
  assign cmd_air = cmd_valid && (cmd_code == esc_pkg::CMD_AIR);
  assign cmd_lock = cmd_valid && (cmd_code == esc_pkg::CMD_LOCK);
  assign cmd_alt = cmd_valid && (cmd_code == esc_pkg::CMD_ANT_ALT);
  assign cmd_top = cmd_valid && (cmd_code == esc_pkg::CMD_ANT_TOP);

  always_comb begin
    force_nxt = force_r;
    force_ms_nxt = force_ms_r;
    if (tick && force_ms_r != 16'h0) begin
      force_ms_nxt = force_ms_r - 16'h1;
    end
    if (tick && force_ms_r == 16'h1) begin
      force_nxt = esc_pkg::FORCE_NONE;
    end
    if (takeoff && force_r == esc_pkg::FORCE_SURF) begin
      force_nxt = esc_pkg::FORCE_NONE;
      force_ms_nxt = 16'h0;
    end
    if (cmd_surf) begin
      force_nxt = esc_pkg::FORCE_SURF;
      force_ms_nxt = esc_pkg::SURF_CMD_MS;
    end else if (cmd_air) begin
      force_nxt = esc_pkg::FORCE_AIR;
      force_ms_nxt = esc_pkg::AIR_CMD_MS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      force_r <= esc_pkg::FORCE_NONE;
      force_ms_r <= 16'h0;
    end else begin
      force_r <= force_nxt;
      force_ms_r <= force_ms_nxt;
    end
  end

  // Format selection
  logic surface_fmt;
  logic sensed_gnd;
  assign sensed_gnd = sense_en && gnd_r;
  assign surface_fmt = (force_r == esc_pkg::FORCE_SURF) ||
                       ((force_r == esc_pkg::FORCE_NONE) && sensed_gnd);

  // Capability code ignores format commands
  logic [2:0] ca_nxt;
  assign ca_nxt = !sense_en ? esc_pkg::CA_NOSENSE :
                  (gnd_r ? esc_pkg::CA_GND : esc_pkg::CA_AIR);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ca_code <= esc_pkg::CA_NOSENSE;
      cap_es <= 1'b0;
    end else begin
      ca_code <= ca_nxt;
      cap_es <= 1'b1;
    end
  end

  // Surface squitter lockout
  logic [15:0] lock_ms_r;
  logic lock_active;
  assign lock_active = (lock_ms_r != 16'h0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_ms_r <= 16'h0;
    end else if (cmd_lock && surface_fmt) begin
      lock_ms_r <= esc_pkg::LOCK_MS;
    end else if (tick && lock_active) begin
      lock_ms_r <= lock_ms_r - 16'h1;
    end
  end

  // Surface antenna mode
  logic sas_alt_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sas_alt_r <= 1'b0;
    end else if (cmd_alt) begin
      sas_alt_r <= 1'b1;
    end else if (cmd_top) begin
      sas_alt_r <= 1'b0;
    end
  end

  // Time-limited data registers
  logic [DATA_W-1:0] dreg_r [NDREG_W];
  logic [15:0] stale_ms_r [NDREG_W];
  logic [15:0] hold_ms_r [NDREG_W];
  logic [NDREG_W-1:0] started_r;
  logic [NDREG_W-1:0] active;
  logic [DATA_W-1:0] ins_word;
  logic [DATA_W-1:0] keep_mask;
  assign ins_word = (DATA_W'(ins_alt) << esc_pkg::INS_ALT_LSB) |
                    (DATA_W'(ins_ss) << esc_pkg::INS_SS_LSB);
  assign keep_mask = DATA_W'(esc_pkg::INS_MASK);

  genvar gi;
  generate
    for (gi = 0; gi < NDREG_W; gi++) begin : g_dreg
      localparam bit STALE_ON = esc_pkg::STALE_SEL[gi];
      localparam bit IS_APOS = (gi == esc_pkg::DR_APOS);
      logic expire;
      logic [DATA_W-1:0] cleared;
      assign expire = STALE_ON && tick && (stale_ms_r[gi] == 16'h1);
      assign cleared = IS_APOS ? (dreg_r[gi] & keep_mask) : '0;
      assign active[gi] = started_r[gi] && (hold_ms_r[gi] != 16'h0);

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          dreg_r[gi] <= '0;
          stale_ms_r[gi] <= 16'h0;
          hold_ms_r[gi] <= 16'h0;
          started_r[gi] <= 1'b0;
        end else if (wr_dreg[gi]) begin
          dreg_r[gi] <= reg_wdata;
          stale_ms_r[gi] <= esc_pkg::STALE_MS;
          hold_ms_r[gi] <= esc_pkg::HOLD_MS;
          started_r[gi] <= 1'b1;
        end else begin
          if (IS_APOS && ins_valid) begin
            dreg_r[gi] <= ((expire ? cleared : dreg_r[gi]) & ~keep_mask) | ins_word;
          end else if (expire) begin
            dreg_r[gi] <= cleared;
          end
          if (tick && stale_ms_r[gi] != 16'h0) begin
            stale_ms_r[gi] <= stale_ms_r[gi] - 16'h1;
          end
          if (tick && hold_ms_r[gi] != 16'h0) begin
            hold_ms_r[gi] <= hold_ms_r[gi] - 16'h1;
          end
        end
      end
    end
  endgenerate

  // Event register: one broadcast per load, no staleness
  logic [DATA_W-1:0] event_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_r <= '0;
    end else if (wr_event) begin
      event_r <= reg_wdata;
    end
  end

  // Pseudo-random launch instants
  logic [15:0] lfsr_r;
  logic [15:0] due_ms_r;
  logic launch;
  assign launch = tick && (due_ms_r == 16'h0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr_r <= esc_pkg::LFSR_SEED;
      due_ms_r <= 16'h0;
    end else begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ esc_pkg::LFSR_TAPS) : (lfsr_r >> 1);
      if (launch) begin
        due_ms_r <= esc_pkg::SQ_BASE_MS + {8'h00, lfsr_r[7:0]};
      end else if (tick) begin
        due_ms_r <= due_ms_r - 16'h1;
      end
    end
  end

  // Pending squitters per type
  localparam int NTYPE_W = esc_pkg::NTYPE;
  logic [NTYPE_W-1:0] pend_r, pend_set, pend_take, pend_nxt;
  assign pend_set[esc_pkg::TX_ACQ] = launch;
  assign pend_set[esc_pkg::TX_APOS] = launch && active[esc_pkg::DR_APOS] && !surface_fmt;
  assign pend_set[esc_pkg::TX_SPOS] = launch && active[esc_pkg::DR_SPOS] &&
                                      surface_fmt && !lock_active;
  assign pend_set[esc_pkg::TX_IDENT] = launch && active[esc_pkg::DR_IDENT];
  assign pend_set[esc_pkg::TX_AVEL] = launch && active[esc_pkg::DR_AVEL] && !surface_fmt;
  assign pend_set[esc_pkg::TX_EVENT] = wr_event;
  assign pend_nxt = pend_set | (pend_r & ~pend_take);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Fixed-priority pick, lowest type first
  logic [2:0] pick;
  logic any_pend;
  logic load_tx;
  assign any_pend = |pend_r;

  always_comb begin
    pick = 3'h0;
    for (int k = NTYPE_W - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pick = 3'(k);
      end
    end
  end

  assign load_tx = any_pend && !tx_valid;
  assign pend_take = load_tx ? (NTYPE_W'(1) << pick) : '0;

  logic [DATA_W-1:0] pick_data;
  always_comb begin
    unique case (esc_pkg::esc_tx_t'(pick))
      esc_pkg::TX_APOS: pick_data = dreg_r[esc_pkg::DR_APOS];
      esc_pkg::TX_SPOS: pick_data = dreg_r[esc_pkg::DR_SPOS];
      esc_pkg::TX_IDENT: pick_data = dreg_r[esc_pkg::DR_IDENT];
      esc_pkg::TX_AVEL: pick_data = dreg_r[esc_pkg::DR_AVEL];
      esc_pkg::TX_EVENT: pick_data = event_r;
      default: pick_data = '0;
    endcase
  end

  // Antenna choice
  logic alt_ok;
  logic ant_tgl_r;
  assign alt_ok = dual_ant && (!surface_fmt || sas_alt_r);

  // Transmit stage holds until the transmitter accepts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_type <= 3'h0;
      tx_data <= '0;
      tx_ant_bottom <= 1'b0;
      ant_tgl_r <= 1'b0;
    end else if (load_tx) begin
      tx_valid <= 1'b1;
      tx_type <= pick;
      tx_data <= pick_data;
      tx_ant_bottom <= alt_ok && ant_tgl_r;
      ant_tgl_r <= alt_ok ? !ant_tgl_r : 1'b0;
    end else if (tx_valid && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Register read mux
  logic [DATA_W-1:0] status_w;
  logic [DATA_W-1:0] rd_mux;
  assign status_w = DATA_W'({ca_nxt, gnd_r, active, force_r != esc_pkg::FORCE_NONE,
                             lock_active, surface_fmt});
  assign rd_mux = (reg_addr == ADDR_W'(esc_pkg::ADR_CTRL)) ? DATA_W'(ctrl_r) :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_STATUS)) ? status_w :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_CAP)) ?
                    (DATA_W'(1) << esc_pkg::CAP_ES_BIT) :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_APOS)) ? dreg_r[esc_pkg::DR_APOS] :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_SPOS)) ? dreg_r[esc_pkg::DR_SPOS] :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_IDENT)) ? dreg_r[esc_pkg::DR_IDENT] :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_AVEL)) ? dreg_r[esc_pkg::DR_AVEL] :
                  (reg_addr == ADDR_W'(esc_pkg::ADR_EVENT)) ? event_r : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule // esc_ctrl
`default_nettype wire

// ===== pkg/esc_pkg.sv
package esc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam logic [15:0] STALE_MS = 16'd2000;
  localparam logic [15:0] HOLD_MS = 16'd60000;
  localparam logic [15:0] LOCK_MS = 16'd60000;
  localparam logic [15:0] SURF_CMD_MS = 16'd60000;
  localparam logic [15:0] AIR_CMD_MS = 16'd60000;
  localparam logic [15:0] SQ_BASE_MS = 16'd400;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CAP = 8'h08;
  localparam logic [7:0] ADR_APOS = 8'h10;
  localparam logic [7:0] ADR_SPOS = 8'h14;
  localparam logic [7:0] ADR_IDENT = 8'h18;
  localparam logic [7:0] ADR_AVEL = 8'h1C;
  localparam logic [7:0] ADR_EVENT = 8'h20;
  localparam int CTRL_SENSE_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CAP_ES_BIT = 22;
  localparam logic [2:0] CA_GND = 3'h4;
  localparam logic [2:0] CA_AIR = 3'h5;
  localparam logic [2:0] CA_NOSENSE = 3'h6;
  localparam int INS_SS_LSB = 0;
  localparam int INS_ALT_LSB = 2;
  localparam logic [31:0] INS_MASK = 32'h00003FFF;
  localparam int NDREG = 4;
  localparam int DR_APOS = 0;
  localparam int DR_SPOS = 1;
  localparam int DR_IDENT = 2;
  localparam int DR_AVEL = 3;
  localparam logic [3:0] STALE_SEL = 4'hB;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_SURF = 3'b001,
    CMD_AIR = 3'b010,
    CMD_LOCK = 3'b011,
    CMD_ANT_ALT = 3'b100,
    CMD_ANT_TOP = 3'b101
  } esc_cmd_t;
  typedef enum logic [1:0] {
    FORCE_NONE = 2'b00,
    FORCE_SURF = 2'b01,
    FORCE_AIR = 2'b10
  } esc_force_t;
  typedef enum logic [2:0] {
    TX_ACQ = 3'b000,
    TX_APOS = 3'b001,
    TX_SPOS = 3'b010,
    TX_IDENT = 3'b011,
    TX_AVEL = 3'b100,
    TX_EVENT = 3'b101
  } esc_tx_t;
  localparam int NTYPE = 6;
endpackage

// ===== bench/esc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module esc_ctrl_monitor #(
  parameter int TICK_CYC = esc_pkg::TICK_CYC,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic on_ground_pin,
  input wire logic cmd_valid,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [2:0] tx_type,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_ant_bottom,
  input wire logic [2:0] ca_code,
  input wire logic cap_es
);
  localparam int ACQ_LIMIT = (int'(esc_pkg::SQ_BASE_MS) + 260) * TICK_CYC + 64;
  logic [3:0] seen_r;
  logic [31:0] acq_gap_r;
  wire logic [3:0] load_hit = {reg_addr == ADDR_W'(esc_pkg::ADR_AVEL),
    reg_addr == ADDR_W'(esc_pkg::ADR_IDENT), reg_addr == ADDR_W'(esc_pkg::ADR_SPOS),
    reg_addr == ADDR_W'(esc_pkg::ADR_APOS)};
  wire logic acq_take = tx_valid && tx_ready && tx_type == esc_pkg::TX_ACQ;
  always_ff @(posedge sys_clk) begin
    if (rst) seen_r <= 4'h0;
    else if (reg_wr) seen_r <= seen_r | load_hit;
  end
  // Sensed ground periods excluded, acquisition there is optional
  always_ff @(posedge sys_clk) begin
    if (rst || acq_take || ca_code == esc_pkg::CA_GND) acq_gap_r <= 32'h0;
    else acq_gap_r <= acq_gap_r + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence tx_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence tx_take;
    tx_valid && tx_ready;
  endsequence
  sequence cmd_alone;
    (!reg_wr && $stable(on_ground_pin))[*6] ##1 (cmd_valid && !reg_wr && $stable(on_ground_pin));
  endsequence
  AST_HOLD: assert property (tx_stall |=> tx_valid && $stable(tx_type) &&
    $stable(tx_data) && $stable(tx_ant_bottom)) else $error("stalled squitter changed");
  AST_GAP: assert property (tx_take |=> !tx_valid)
    else $error("no idle cycle after acceptance");
  AST_ACQ_ZERO: assert property (tx_valid && tx_type == esc_pkg::TX_ACQ |-> tx_data == '0)
    else $error("acquisition word not zero");
  AST_CA_CMD: assert property (cmd_alone |=> $stable(ca_code)[*2])
    else $error("command changed capability code");
  AST_CAP_ES: assert property ((!rst)[*3] |-> cap_es)
    else $error("capability bit missing");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  AST_ES_START: assert property (tx_valid && tx_type inside {[3'h1:3'h4]} |->
    seen_r[tx_type - 3'h1]) else $error("extended squitter before load");
  AST_ACQ_GAP: assert property (acq_gap_r < 32'(ACQ_LIMIT))
    else $error("acquisition squitters stopped");
endmodule // esc_ctrl_monitor
bind esc_ctrl esc_ctrl_monitor #(.TICK_CYC(TICK_CYC), .ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_esc_ctrl_monitor (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .on_ground_pin(on_ground_pin),
  .cmd_valid(cmd_valid), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_type(tx_type),
  .tx_data(tx_data), .tx_ant_bottom(tx_ant_bottom), .ca_code(ca_code), .cap_es(cap_es));
`default_nettype wire

// ===== bench/esc_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module esc_tx_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [2:0] tx_type,
  input wire logic [31:0] tx_data,
  input wire logic tx_ant_bottom,
  output logic tx_ready
);
  int cnt [7];
  logic [31:0] last_data [6];
  logic last_ant;
  logic prev_ant;
  logic [3:0] busy_r;
  // Busy spell after each send while slow is set stands for replies holding the transmitter
  assign tx_ready = (busy_r == 4'h0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_r <= 4'h0;
    end else if (tx_valid && tx_ready) begin
      if (tx_type < 3'h6) cnt[tx_type] <= cnt[tx_type] + 1;
      cnt[6] <= cnt[6] + 1;
      if (tx_type < 3'h6) last_data[tx_type] <= tx_data;
      prev_ant <= last_ant;
      last_ant <= tx_ant_bottom;
      busy_r <= slow ? 4'h6 : 4'h0;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end
endmodule // esc_tx_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst, reg_wr, reg_rd, on_ground_pin, cmd_valid, ins_valid, slow;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, q;
  logic [2:0] cmd_code;
  logic [11:0] ins_alt;
  logic [1:0] ins_ss;
  wire logic tx_ready, tx_valid, tx_ant_bottom, cap_es;
  wire logic [2:0] tx_type, ca_code;
  wire logic [31:0] reg_rdata, tx_data;
  int errors = 0;
  int num_checks = 0;
  esc_ctrl #(.TICK_CYC(4)) u_esc_ctrl (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .on_ground_pin(on_ground_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .ins_valid(ins_valid), .ins_alt(ins_alt), .ins_ss(ins_ss), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_type(tx_type), .tx_data(tx_data),
    .tx_ant_bottom(tx_ant_bottom), .ca_code(ca_code), .cap_es(cap_es));
  esc_tx_model u_esc_tx_model (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .tx_valid(tx_valid), .tx_type(tx_type), .tx_data(tx_data),
    .tx_ant_bottom(tx_ant_bottom), .tx_ready(tx_ready));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(esc_pkg::ADR_STATUS);
    chk(q & m, e);
  endtask
  task automatic cmd(input logic [2:0] c);
    @(posedge sys_clk);
    cmd_code <= c;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  // Index 6 waits on any squitter type
  task automatic wait_acc(input int ty, input int n);
    int base;
    base = u_esc_tx_model.cnt[ty];
    for (int i = 0; i < 8000 && u_esc_tx_model.cnt[ty] < base + n; i++) @(posedge sys_clk);
    if (u_esc_tx_model.cnt[ty] < base + n) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic ant_pair(input logic [31:0] e);
    wait_acc(6, 1);
    wait_acc(6, 2);
    chk(32'({u_esc_tx_model.last_ant, u_esc_tx_model.prev_ant}), e);
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    on_ground_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    ins_valid = 1'b0;
    ins_alt = 12'h0;
    ins_ss = 2'h0;
    slow = 1'b0;
    cyc(6);
    rst <= 1'b0;
    #1 chk(32'(ca_code), 32'(esc_pkg::CA_NOSENSE));
    cyc(2);
    #1 chk(32'(cap_es), 32'h1);
    rd(esc_pkg::ADR_CAP);
    chk(32'(q[esc_pkg::CAP_ES_BIT]), 32'h1);
    wait_acc(0, 1);
    chk(u_esc_tx_model.last_data[0], 32'h0);
    st(32'h7F, 32'h0);
    cmd(esc_pkg::CMD_LOCK);
    st(32'h2, 32'h0);
    cmd(esc_pkg::CMD_SURF);
    st(32'h5, 32'h5);
    cmd(esc_pkg::CMD_LOCK);
    st(32'h7, 32'h7);
    chk(32'(ca_code), 32'(esc_pkg::CA_NOSENSE));
    cmd(esc_pkg::CMD_AIR);
    st(32'h1, 32'h0);
    wr(esc_pkg::ADR_CTRL, 32'h1);
    on_ground_pin <= 1'b1;
    cyc(8);
    st(32'h1, 32'h0);
    chk(32'(ca_code), 32'(esc_pkg::CA_GND));
    cmd(esc_pkg::CMD_SURF);
    st(32'h1, 32'h1);
    on_ground_pin <= 1'b0;
    cyc(8);
    st(32'h1, 32'h0);
    chk(32'(ca_code), 32'(esc_pkg::CA_AIR));
    on_ground_pin <= 1'b1;
    cyc(8);
    st(32'h1, 32'h1);
    on_ground_pin <= 1'b0;
    cyc(8);
    st(32'h1, 32'h0);
    wr(esc_pkg::ADR_CTRL, 32'h3);
    wr(esc_pkg::ADR_APOS, 32'h11);
    wr(esc_pkg::ADR_AVEL, 32'h22);
    wr(esc_pkg::ADR_IDENT, 32'h33);
    ant_pair(32'h1);
    ant_pair(32'h2);
    on_ground_pin <= 1'b1;
    // Drain airborne leftovers first
    wait_acc(0, 1);
    ant_pair(32'h0);
    cmd(esc_pkg::CMD_ANT_ALT);
    ant_pair(32'h1);
    cmd(esc_pkg::CMD_ANT_TOP);
    on_ground_pin <= 1'b0;
    slow <= 1'b1;
    cyc(8);
    wr(esc_pkg::ADR_APOS, 32'h12345678);
    cyc(3900);
    @(posedge sys_clk);
    ins_alt <= 12'hABC;
    ins_ss <= 2'h2;
    ins_valid <= 1'b1;
    @(posedge sys_clk);
    ins_valid <= 1'b0;
    cyc(3900);
    rd(esc_pkg::ADR_APOS);
    chk(q, 32'h12346AF2);
    cyc(300);
    rd(esc_pkg::ADR_APOS);
    chk(q, 32'h00002AF2);
    st(32'h8, 32'h8);
    wait_acc(1, 1);
    wr(esc_pkg::ADR_APOS, 32'h0F0F0000);
    cyc(6000);
    wr(esc_pkg::ADR_APOS, 32'h0F0F0000);
    cyc(4000);
    rd(esc_pkg::ADR_APOS);
    chk(q, 32'h0F0F0000);
    wr(esc_pkg::ADR_EVENT, 32'h00000A5A);
    wait_acc(5, 1);
    chk(u_esc_tx_model.last_data[5], 32'h00000A5A);
    cyc(8100);
    rd(esc_pkg::ADR_EVENT);
    chk(q, 32'h00000A5A);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
